// file: bench/tb_two_wire_flash_program_regs.sv
// Self-checking bench: host end and device end joined over the link
`timescale 1ns/1ps
`default_nettype none

module tb_two_wire_flash_program_regs;
  logic               clk;
  logic               reset;
  logic               haltReq;
  logic               hostCmdValid;
  logic               cmdReady;
  logic [1:0]         cmdIns;
  logic [7:0]         cmdByte;
  logic               rspValid;
  logic [7:0]         rspByte;
  logic               progEnabled;
  logic               normalRun;
  logic               peripheralStall;
  logic               flashWrite;
  logic [7:0]         flashByte;
  logic               devCmdValid;
  tfp_pkg::tfp_kind_t cmdKind;
  tfp_pkg::tfp_kind_t lastKind;
  logic [10:0]        wireBits;
  logic               prevLinkClk;
  logic [7:0]         rd;
  logic [7:0]         val;
  logic [7:0]         codes [5];
  int                 fails;
  int                 checks;
  int                 cycles;
  int                 writeCount;
  int                 cmdCount;
  int                 expCmd;

  tfp_link_if tfp_link_if_inst ();

  tfp_host_end tfp_host_end_inst (.clk(clk), .reset(reset), .lnk(tfp_link_if_inst),
    .cmdValid(hostCmdValid), .cmdReady(cmdReady), .cmdIns(cmdIns), .cmdByte(cmdByte),
    .rspValid(rspValid), .rspByte(rspByte));

  tfp_device_end tfp_device_end_inst (.clk(clk), .reset(reset), .lnk(tfp_link_if_inst),
    .haltReq(haltReq), .progEnabled(progEnabled), .normalRun(normalRun),
    .peripheralStall(peripheralStall), .flashWrite(flashWrite), .flashByte(flashByte),
    .cmdValid(devCmdValid), .cmdKind(cmdKind));

  tfp_link_properties tfp_link_properties_inst (.clk(clk), .reset(reset),
    .linkClk(tfp_link_if_inst.linkClk), .hostDataOut(tfp_link_if_inst.hostDataOut),
    .hostDataOe(tfp_link_if_inst.hostDataOe), .devDataOe(tfp_link_if_inst.devDataOe),
    .haltReq(haltReq), .progEnabled(progEnabled), .normalRun(normalRun),
    .peripheralStall(peripheralStall), .flashWrite(flashWrite), .flashByte(flashByte),
    .cmdValid(devCmdValid), .cmdKind(cmdKind));

  // Free-running system clock, 100 ns period
  always #50 clk = ~clk;

  // Wire bits at each link clock rise, device pulses, hang guard
  always @(posedge clk) begin
    prevLinkClk <= tfp_link_if_inst.linkClk;
    if (tfp_link_if_inst.linkClk && !prevLinkClk) begin
      wireBits <= {tfp_link_if_inst.dataLevel, wireBits[10:1]};
    end
    if (flashWrite === 1'b1) begin
      writeCount <= writeCount + 1;
    end
    if (devCmdValid === 1'b1) begin
      cmdCount <= cmdCount + 1;
      lastKind <= cmdKind;
    end
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic tfp_pkg::tfp_kind_t kindOf(input logic [7:0] b);
    case (b)
      8'h06: return tfp_pkg::KIND_BLOCK_READ;
      8'h07: return tfp_pkg::KIND_BLOCK_WRITE;
      8'h08: return tfp_pkg::KIND_PAGE_ERASE;
      8'h03: return tfp_pkg::KIND_DEVICE_ERASE;
      default: return tfp_pkg::KIND_NONE;
    endcase
  endfunction

  // One frame: request held until taken, then bounded wait for the answer
  task automatic doCmd(input logic [1:0] ins, input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk);
    hostCmdValid <= 1'b1;
    cmdIns <= ins;
    cmdByte <= b;
    do begin
      @(posedge clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 400);
    check({7'h0, cmdReady}, 8'h01);
    check({7'h0, tfp_link_if_inst.linkClk}, 8'h00);
    hostCmdValid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rspValid !== 1'b1 && n < 400);
    check({7'h0, rspValid}, 8'h01);
    rd = rspByte;
    // Settle time for the wire monitor and the clock crossing
    repeat (8) @(posedge clk);
    // Idle line held low by the host, clock pin quiet
    check({6'h0, tfp_link_if_inst.hostDataOe, tfp_link_if_inst.dataLevel}, 8'h02);
    check({7'h0, tfp_link_if_inst.linkClk}, 8'h00);
    if (ins[0]) begin
      check({ins, wireBits[2:0]}, {ins, ins, 1'b1});
      check(wireBits[10:3], b);
    end
  endtask

  task automatic wrReg(input logic [7:0] sel, input logic [7:0] v);
    doCmd(tfp_pkg::INS_ADDR_WRITE, sel);
    doCmd(tfp_pkg::INS_DATA_WRITE, v);
  endtask

  task automatic rdReg(input logic [7:0] sel);
    doCmd(tfp_pkg::INS_ADDR_WRITE, sel);
    doCmd(tfp_pkg::INS_DATA_READ, 8'h00);
  endtask

  task automatic doReset();
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    haltReq = 1'b0;
    hostCmdValid = 1'b0;
    cmdIns = 2'h0;
    cmdByte = 8'h00;
    prevLinkClk = 1'b0;
    wireBits = 11'h000;
    fails = 0;
    checks = 0;
    cycles = 0;
    writeCount = 0;
    cmdCount = 0;
    void'($urandom(32'h9aa4));
    doReset();
    // Reset values seen over the link
    doCmd(tfp_pkg::INS_ADDR_READ, 8'h00);
    check(rd, 8'h00);
    rdReg(tfp_pkg::CTRL_ADDR);
    check(rd, 8'h00);
    rdReg(tfp_pkg::DATA_ADDR);
    check(rd, 8'h00);
    check({7'h0, normalRun}, 8'h01);
    // Halt stalls before any unlock
    haltReq <= 1'b1;
    repeat (2) @(posedge clk);
    check({7'h0, peripheralStall}, 8'h01);
    haltReq <= 1'b0;
    // Locked data write stores but raises nothing
    val = 8'($urandom);
    wrReg(tfp_pkg::DATA_ADDR, val);
    rdReg(tfp_pkg::DATA_ADDR);
    check(rd, val);
    check(writeCount[7:0], 8'h00);
    // Unmapped select ignores writes, reads zero
    wrReg(8'h10 + 8'($urandom % 128), ~val);
    doCmd(tfp_pkg::INS_DATA_READ, 8'h00);
    check(rd, 8'h00);
    rdReg(tfp_pkg::DATA_ADDR);
    check(rd, val);
    // Broken unlock orders, then lone second code
    val = 8'($urandom);
    if (val == 8'h01 || val == 8'h02) val = 8'h55;
    wrReg(tfp_pkg::CTRL_ADDR, 8'h02);
    doCmd(tfp_pkg::INS_DATA_WRITE, val);
    check({7'h0, progEnabled}, 8'h00);
    doCmd(tfp_pkg::INS_DATA_WRITE, 8'h01);
    check({7'h0, progEnabled}, 8'h00);
    doCmd(tfp_pkg::INS_DATA_READ, 8'h00);
    check(rd, 8'h01);
    // Repeated first code restarts; ordered pair unlocks
    doCmd(tfp_pkg::INS_DATA_WRITE, 8'h02);
    doCmd(tfp_pkg::INS_DATA_WRITE, 8'h02);
    doCmd(tfp_pkg::INS_DATA_WRITE, 8'h01);
    check({7'h0, progEnabled}, 8'h01);
    check({7'h0, normalRun}, 8'h00);
    doCmd(tfp_pkg::INS_DATA_WRITE, 8'h00);
    check({7'h0, progEnabled}, 8'h01);
    // Every command code plus a random byte, halt wandering
    codes = '{8'h06, 8'h07, 8'h08, 8'h03, 8'($urandom)};
    expCmd = 0;
    doCmd(tfp_pkg::INS_ADDR_WRITE, tfp_pkg::DATA_ADDR);
    for (int i = 0; i < 5; i++) begin
      haltReq <= 1'($urandom);
      doCmd(tfp_pkg::INS_DATA_WRITE, codes[i]);
      if (kindOf(codes[i]) != tfp_pkg::KIND_NONE) expCmd++;
      check(writeCount[7:0], 8'(i + 1));
      check(cmdCount[7:0], expCmd[7:0]);
      if (kindOf(codes[i]) != tfp_pkg::KIND_NONE) begin
        check({5'h0, lastKind}, {5'h0, kindOf(codes[i])});
      end
      check(flashByte, codes[i]);
    end
    doCmd(tfp_pkg::INS_DATA_READ, 8'h00);
    check(rd, codes[4]);
    // Only a system reset leaves programming
    doReset();
    check({7'h0, progEnabled}, 8'h00);
    rdReg(tfp_pkg::CTRL_ADDR);
    check(rd, 8'h00);
    rdReg(tfp_pkg::DATA_ADDR);
    check(rd, 8'h00);
    tally_and_finish();
  end
endmodule

`default_nettype wire

// file: bench/tfp_link_properties.sv
// Concurrent checks on the link wires and the device outputs
`timescale 1ns/1ps
`default_nettype none

module tfp_link_properties (
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               linkClk,
  input wire logic               hostDataOut,
  input wire logic               hostDataOe,
  input wire logic               devDataOe,
  input wire logic               haltReq,
  input wire logic               progEnabled,
  input wire logic               normalRun,
  input wire logic               peripheralStall,
  input wire logic               flashWrite,
  input wire logic [7:0]         flashByte,
  input wire logic               cmdValid,
  input wire tfp_pkg::tfp_kind_t cmdKind
);
  tfp_pkg::tfp_kind_t kindExp;

  // Kind a data byte must decode to; non-commands give none
  assign kindExp = (flashByte == 8'h06) ? tfp_pkg::KIND_BLOCK_READ :
                   (flashByte == 8'h07) ? tfp_pkg::KIND_BLOCK_WRITE :
                   (flashByte == 8'h08) ? tfp_pkg::KIND_PAGE_ERASE :
                   (flashByte == 8'h03) ? tfp_pkg::KIND_DEVICE_ERASE : tfp_pkg::KIND_NONE;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_single_driver: assert property (!(hostDataOe && devDataOe))
    else $error("both ends drive the data line");
  a_clock_half: assert property ($rose(linkClk) |-> linkClk [*4] ##1 !linkClk)
    else $error("link clock high phase not four cycles");
  a_host_steady: assert property (linkClk && $past(linkClk) && hostDataOe |-> $stable(hostDataOut))
    else $error("host data moved while link clock high");
  a_run_flag: assert property (normalRun == !progEnabled)
    else $error("normal run flag disagrees with programming state");
  a_prog_sticky: assert property (progEnabled |=> progEnabled)
    else $error("programming dropped without reset");
  a_stall_halt: assert property (peripheralStall == (haltReq || progEnabled))
    else $error("stall does not follow halt");
  a_cmd_enabled: assert property (cmdValid |-> progEnabled && flashWrite)
    else $error("command pulse without enabled write");
  a_kind_decode: assert property (cmdValid |-> cmdKind == kindExp)
    else $error("command kind does not match byte");
  a_cmd_complete: assert property (flashWrite && kindExp != tfp_pkg::KIND_NONE |-> cmdValid)
    else $error("command byte written without command pulse");
  a_write_pulse: assert property (flashWrite |=> !flashWrite)
    else $error("write pulse longer than one cycle");
endmodule

`default_nettype wire

// file: hw/tfp_device_end.sv
// Target end: link slave, flash programming registers and unlock logic
`timescale 1ns/1ps
`default_nettype none

module tfp_device_end (
  input  wire logic           clk,
  input  wire logic           reset,
  tfp_link_if.dev             lnk,
  input  wire logic           haltReq,
  output logic                progEnabled,
  output logic                normalRun,
  output logic                peripheralStall,
  output logic                flashWrite,
  output logic [7:0]          flashByte,
  output logic                cmdValid,
  output tfp_pkg::tfp_kind_t  cmdKind
);

  typedef enum logic [2:0] {
    L_IDLE,
    L_INS,
    L_WDATA,
    L_TURN,
    L_RDATA
  } tfp_lstate_t;

  typedef enum logic [1:0] {
    U_LOCKED,
    U_GOT_FIRST,
    U_ENABLED
  } tfp_ustate_t;

  // ---------------- Link clock domain ----------------

  logic        lrst1_q;
  logic        lrst2_q;
  tfp_lstate_t lstate_q;
  logic [2:0]  bitCnt_q;
  logic [1:0]  insSh_q;
  logic [7:0]  rxSh_q;
  logic [7:0]  txSh_q;
  logic        dOut_q;
  logic        dOe_q;
  logic [7:0]  select_q;
  logic [7:0]  ctrlReg_q;
  logic [7:0]  dataReg_q;
  logic        evTog_q;
  logic        evCtrl_q;
  logic [7:0]  evByte_q;

  // Link reset: asserts at once, releases on link edges, since the
  // link clock may be stopped while the system reset is applied
  always_ff @(posedge lnk.linkClk or posedge reset) begin
    if (reset) begin
      lrst1_q <= 1'b1;
      lrst2_q <= 1'b1;
    end else begin
      lrst1_q <= 1'b0;
      lrst2_q <= lrst1_q;
    end
  end

  // Data line is launched by the host on the falling edge, so it is
  // already stable and synchronous at our rising edge
  wire       dataIn    = lnk.dataLevel;
  wire [1:0] insNow    = {dataIn, insSh_q[1]};
  wire [7:0] rxNow     = {dataIn, rxSh_q[7:1]};
  wire       insIsWr   = (insNow == tfp_pkg::INS_DATA_WRITE) ||
                         (insNow == tfp_pkg::INS_ADDR_WRITE);
  wire       insDone   = (lstate_q == L_INS) && (bitCnt_q == tfp_pkg::INS_LAST);
  wire       byteDone  = (lstate_q == L_WDATA) && (bitCnt_q == tfp_pkg::BYTE_LAST);
  wire       wrSelect  = byteDone && (insSh_q == tfp_pkg::INS_ADDR_WRITE);
  wire       wrData    = byteDone && (insSh_q == tfp_pkg::INS_DATA_WRITE);
  wire       selCtrl   = (select_q == tfp_pkg::CTRL_ADDR);
  wire       selData   = (select_q == tfp_pkg::DATA_ADDR);

  wire [7:0] dataRdByte = selCtrl ? ctrlReg_q :
                          selData ? dataReg_q : tfp_pkg::UNMAPPED_RD;
  wire [7:0] readByte   = (insSh_q == tfp_pkg::INS_ADDR_READ) ? select_q : dataRdByte;

  always_ff @(posedge lnk.linkClk) begin
    if (lrst2_q) begin
      lstate_q <= L_IDLE;
      bitCnt_q <= 3'h0;
      insSh_q  <= 2'h0;
      rxSh_q   <= 8'h00;
      txSh_q   <= 8'h00;
      dOut_q   <= 1'b0;
      dOe_q    <= 1'b0;
    end else begin
      case (lstate_q)
        L_IDLE: begin
          bitCnt_q <= 3'h0;
          if (dataIn) begin
            lstate_q <= L_INS;
          end
        end
        L_INS: begin
          insSh_q  <= insNow;
          bitCnt_q <= insDone ? 3'h0 : bitCnt_q + 3'h1;
          if (insDone) begin
            lstate_q <= insIsWr ? L_WDATA : L_TURN;
          end
        end
        L_WDATA: begin
          rxSh_q   <= rxNow;
          bitCnt_q <= bitCnt_q + 3'h1;
          if (byteDone) begin
            lstate_q <= L_IDLE;
          end
        end
        L_TURN: begin
          // Take the line only after the host has let go of it
          dOe_q    <= 1'b1;
          dOut_q   <= readByte[0];
          txSh_q   <= {1'b0, readByte[7:1]};
          bitCnt_q <= 3'h0;
          lstate_q <= L_RDATA;
        end
        L_RDATA: begin
          bitCnt_q <= bitCnt_q + 3'h1;
          dOut_q   <= txSh_q[0];
          txSh_q   <= {1'b0, txSh_q[7:1]};
          if (bitCnt_q == tfp_pkg::BYTE_LAST) begin
            dOe_q    <= 1'b0;
            lstate_q <= L_IDLE;
          end
        end
        default: begin
          dOe_q    <= 1'b0;
          lstate_q <= L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge lnk.linkClk) begin
    if (lrst2_q) begin
      select_q <= tfp_pkg::SELECT_RESET;
    end else if (wrSelect) begin
      select_q <= rxNow;
    end
  end

  always_ff @(posedge lnk.linkClk) begin
    if (lrst2_q) begin
      ctrlReg_q <= tfp_pkg::CTRL_RESET;
    end else if (wrData && selCtrl) begin
      ctrlReg_q <= rxNow;
    end
  end

  always_ff @(posedge lnk.linkClk) begin
    if (lrst2_q) begin
      dataReg_q <= tfp_pkg::DATA_RESET;
    end else if (wrData && selData) begin
      dataReg_q <= rxNow;
    end
  end

  // Write event to system side: toggle plus held byte; the byte stays
  // put for a whole frame, far longer than the crossing takes. Cleared
  // by system reset at once, so a stale toggle cannot fake a write later
  always_ff @(posedge lnk.linkClk or posedge reset) begin
    if (reset) begin
      evTog_q  <= 1'b0;
      evCtrl_q <= 1'b0;
      evByte_q <= 8'h00;
    end else if (wrData && (selCtrl || selData)) begin
      evTog_q  <= ~evTog_q;
      evCtrl_q <= selCtrl;
      evByte_q <= rxNow;
    end
  end

  // Drive let go as soon as reset hits, before any link edge arrives
  assign lnk.devDataOut = dOut_q;
  assign lnk.devDataOe  = dOe_q && !lrst2_q;

  // ---------------- System clock domain ----------------

  logic        tgS1_q;
  logic        tgS2_q;
  logic        tgS3_q;
  tfp_ustate_t ustate_q;
  logic        flashWrite_q;
  logic [7:0]  flashByte_q;
  logic        cmdValid_q;
  tfp_pkg::tfp_kind_t cmdKind_q;

  // Toggle synchroniser; the edge detect compares the second and third stages
  always_ff @(posedge clk) begin
    if (reset) begin
      tgS1_q <= 1'b0;
      tgS2_q <= 1'b0;
      tgS3_q <= 1'b0;
    end else begin
      tgS1_q <= evTog_q;
      tgS2_q <= tgS1_q;
      tgS3_q <= tgS2_q;
    end
  end

  wire       evSeen   = tgS2_q ^ tgS3_q;
  wire       ctrlWr   = evSeen && evCtrl_q;
  wire       dataWr   = evSeen && !evCtrl_q;
  wire       enabled  = (ustate_q == U_ENABLED);

  wire tfp_pkg::tfp_kind_t kindNow =
      (evByte_q == tfp_pkg::OP_BLOCK_READ)   ? tfp_pkg::KIND_BLOCK_READ   :
      (evByte_q == tfp_pkg::OP_BLOCK_WRITE)  ? tfp_pkg::KIND_BLOCK_WRITE  :
      (evByte_q == tfp_pkg::OP_PAGE_ERASE)   ? tfp_pkg::KIND_PAGE_ERASE   :
      (evByte_q == tfp_pkg::OP_DEVICE_ERASE) ? tfp_pkg::KIND_DEVICE_ERASE :
                                               tfp_pkg::KIND_NONE;

  always_ff @(posedge clk) begin
    if (reset) begin
      ustate_q <= U_LOCKED;
    end else if (ctrlWr) begin
      case (ustate_q)
        U_LOCKED: begin
          if (evByte_q == tfp_pkg::UNLOCK_FIRST) begin
            ustate_q <= U_GOT_FIRST;
          end
        end
        U_GOT_FIRST: begin
          if (evByte_q == tfp_pkg::UNLOCK_SECOND) begin
            ustate_q <= U_ENABLED;
          end else if (evByte_q == tfp_pkg::UNLOCK_FIRST) begin
            ustate_q <= U_GOT_FIRST;
          end else begin
            ustate_q <= U_LOCKED;
          end
        end
        U_ENABLED: begin
          ustate_q <= U_ENABLED;
        end
        default: begin
          ustate_q <= U_LOCKED;
        end
      endcase
    end
  end

  // Flash traffic passes only while programming is enabled
  always_ff @(posedge clk) begin
    if (reset) begin
      flashWrite_q <= 1'b0;
      flashByte_q  <= 8'h00;
      cmdValid_q   <= 1'b0;
      cmdKind_q    <= tfp_pkg::KIND_NONE;
    end else begin
      flashWrite_q <= dataWr && enabled;
      cmdValid_q   <= dataWr && enabled && (kindNow != tfp_pkg::KIND_NONE);
      if (dataWr && enabled) begin
        flashByte_q <= evByte_q;
        cmdKind_q   <= kindNow;
      end
    end
  end

  assign progEnabled     = enabled;
  assign normalRun       = !enabled;
  assign peripheralStall = haltReq || enabled;
  assign flashWrite      = flashWrite_q;
  assign flashByte       = flashByte_q;
  assign cmdValid        = cmdValid_q;
  assign cmdKind         = cmdKind_q;

endmodule

`default_nettype wire

// file: hw/tfp_host_end.sv
// Programming host end: makes the link clock and serialises frames
`timescale 1ns/1ps
`default_nettype none

module tfp_host_end (
  input  wire logic        clk,
  input  wire logic        reset,
  tfp_link_if.host         lnk,
  input  wire logic        cmdValid,
  output logic             cmdReady,
  input  wire logic [1:0]  cmdIns,
  input  wire logic [7:0]  cmdByte,
  output logic             rspValid,
  output logic [7:0]       rspByte
);

  typedef enum logic [2:0] {
    H_IDLE,
    H_START,
    H_INS,
    H_WDATA,
    H_TURN,
    H_RDATA
  } tfp_hstate_t;

  tfp_hstate_t hstate_q;
  logic [2:0]  divCnt_q;
  logic [2:0]  warm_q;
  logic        clkOut_q;
  logic [2:0]  bitCnt_q;
  logic [1:0]  insSh_q;
  logic [7:0]  txSh_q;
  logic [7:0]  rxSh_q;
  logic        dOut_q;
  logic        dOe_q;
  logic        rxS1_q;
  logic        rxS2_q;
  logic        rspValid_q;
  logic [7:0]  rspByte_q;

  // Clock runs through a frame, to the end of its last period, and for
  // a few warm-up periods after reset so the target's link reset clears
  wire running  = (hstate_q != H_IDLE) || (divCnt_q != 3'h0) || (warm_q != 3'h0);
  wire riseStep = running && (divCnt_q == tfp_pkg::HALF_PERIOD - 3'h1);
  wire fallStep = running && (divCnt_q == tfp_pkg::PERIOD_LAST);
  wire accept   = cmdValid && cmdReady;
  wire lastBit  = (bitCnt_q == tfp_pkg::BYTE_LAST);
  wire insLast  = (bitCnt_q == tfp_pkg::INS_LAST);
  logic [1:0] insCode_q;
  wire isWrite  = (insCode_q == tfp_pkg::INS_DATA_WRITE) ||
                  (insCode_q == tfp_pkg::INS_ADDR_WRITE);

  assign cmdReady = !reset && (hstate_q == H_IDLE) && !running;

  // Read data synchroniser
  always_ff @(posedge clk) begin
    if (reset) begin
      rxS1_q <= 1'b0;
      rxS2_q <= 1'b0;
    end else begin
      rxS1_q <= lnk.dataLevel;
      rxS2_q <= rxS1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      divCnt_q <= 3'h0;
      clkOut_q <= 1'b0;
      warm_q   <= tfp_pkg::WARM_PERIODS;
    end else if (running) begin
      divCnt_q <= divCnt_q + 3'h1;
      if (riseStep) begin
        clkOut_q <= 1'b1;
      end
      if (fallStep) begin
        clkOut_q <= 1'b0;
        if (warm_q != 3'h0) begin
          warm_q <= warm_q - 3'h1;
        end
      end
    end
  end

  // Frame sequencer: advance at rise, change drive at fall
  always_ff @(posedge clk) begin
    if (reset) begin
      hstate_q   <= H_IDLE;
      bitCnt_q   <= 3'h0;
      insSh_q    <= 2'h0;
      insCode_q  <= 2'h0;
      txSh_q     <= 8'h00;
      rxSh_q     <= 8'h00;
      rspValid_q <= 1'b0;
      rspByte_q  <= 8'h00;
    end else begin
      rspValid_q <= 1'b0;
      case (hstate_q)
        H_IDLE: begin
          if (accept) begin
            hstate_q  <= H_START;
            insSh_q   <= cmdIns;
            insCode_q <= cmdIns;
            txSh_q    <= cmdByte;
            bitCnt_q  <= 3'h0;
          end
        end
        H_START: begin
          if (riseStep) begin
            hstate_q <= H_INS;
          end
        end
        H_INS: begin
          if (riseStep) begin
            insSh_q  <= {1'b0, insSh_q[1]};
            bitCnt_q <= insLast ? 3'h0 : bitCnt_q + 3'h1;
            if (insLast) begin
              hstate_q <= isWrite ? H_WDATA : H_TURN;
            end
          end
        end
        H_WDATA: begin
          if (riseStep) begin
            txSh_q   <= {1'b0, txSh_q[7:1]};
            bitCnt_q <= bitCnt_q + 3'h1;
            if (lastBit) begin
              hstate_q   <= H_IDLE;
              rspValid_q <= 1'b1;
            end
          end
        end
        H_TURN: begin
          if (riseStep) begin
            bitCnt_q <= 3'h0;
            hstate_q <= H_RDATA;
          end
        end
        H_RDATA: begin
          if (riseStep) begin
            rxSh_q   <= {rxS2_q, rxSh_q[7:1]};
            bitCnt_q <= bitCnt_q + 3'h1;
            if (lastBit) begin
              hstate_q   <= H_IDLE;
              rspValid_q <= 1'b1;
              rspByte_q  <= {rxS2_q, rxSh_q[7:1]};
            end
          end
        end
        default: begin
          hstate_q <= H_IDLE;
        end
      endcase
    end
  end

  // Line drive: start bit at accept, then one bit per falling edge;
  // between frames the line is held low and steady
  always_ff @(posedge clk) begin
    if (reset) begin
      dOut_q <= 1'b0;
      dOe_q  <= 1'b1;
    end else if (accept) begin
      dOut_q <= 1'b1;
      dOe_q  <= 1'b1;
    end else if (fallStep) begin
      case (hstate_q)
        H_INS: begin
          dOut_q <= insSh_q[0];
          dOe_q  <= 1'b1;
        end
        H_WDATA: begin
          dOut_q <= txSh_q[0];
          dOe_q  <= 1'b1;
        end
        H_TURN, H_RDATA: begin
          dOut_q <= 1'b0;
          dOe_q  <= 1'b0;
        end
        default: begin
          dOut_q <= 1'b0;
          dOe_q  <= 1'b1;
        end
      endcase
    end
  end

  // clock pin only driven, never read back
  assign lnk.linkClk     = clkOut_q;
  assign lnk.hostDataOut = dOut_q;
  assign lnk.hostDataOe  = dOe_q;
  assign rspValid        = rspValid_q;
  assign rspByte         = rspByte_q;

endmodule

`default_nettype wire

// file: hw/tfp_link_if.sv
// Two-wire link between programming host and target device
`timescale 1ns/1ps
`default_nettype none

interface tfp_link_if;
  logic linkClk;
  logic hostDataOut;
  logic hostDataOe;
  logic devDataOut;
  logic devDataOe;
  logic dataLevel;

  // Wire level from the two enables; weak pull-down when nobody drives
  assign dataLevel = hostDataOe ? hostDataOut : (devDataOe ? devDataOut : 1'b0);

  modport host (
    output linkClk,
    output hostDataOut,
    output hostDataOe,
    input  dataLevel
  );

  modport dev (
    input  linkClk,
    output devDataOut,
    output devDataOe,
    input  dataLevel
  );
endinterface

`default_nettype wire

// file: hw/tfp_pkg.sv
// Shared constants and types for the two-wire flash programming link
package tfp_pkg;

  // Register selections seen through the select register
  localparam logic [7:0] CTRL_ADDR    = 8'h02;
  localparam logic [7:0] DATA_ADDR    = 8'hB4;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_RD  = 8'h00;

  // Ordered unlock codes for the control register
  localparam logic [7:0] UNLOCK_FIRST  = 8'h02;
  localparam logic [7:0] UNLOCK_SECOND = 8'h01;

  // Flash command bytes carried by the data register
  localparam logic [7:0] OP_BLOCK_READ   = 8'h06;
  localparam logic [7:0] OP_BLOCK_WRITE  = 8'h07;
  localparam logic [7:0] OP_PAGE_ERASE   = 8'h08;
  localparam logic [7:0] OP_DEVICE_ERASE = 8'h03;

  // Link instruction codes, sent low bit first after the start bit
  localparam logic [1:0] INS_DATA_READ  = 2'h0;
  localparam logic [1:0] INS_DATA_WRITE = 2'h1;
  localparam logic [1:0] INS_ADDR_READ  = 2'h2;
  localparam logic [1:0] INS_ADDR_WRITE = 2'h3;

  // Frame geometry
  localparam logic [2:0] INS_LAST  = 3'h1;
  localparam logic [2:0] BYTE_LAST = 3'h7;

  // Host link clock: half period in system clocks, idle periods after reset
  localparam logic [2:0] HALF_PERIOD  = 3'h4;
  localparam logic [2:0] PERIOD_LAST  = 3'h7;
  localparam logic [2:0] WARM_PERIODS = 3'h4;

  // Decoded flash command kinds
  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_BLOCK_READ,
    KIND_BLOCK_WRITE,
    KIND_PAGE_ERASE,
    KIND_DEVICE_ERASE
  } tfp_kind_t;

endpackage
